// ==== port_ctrl_zero_pkg.sv ====
// package: offsets, bit positions and reset values of the per-port control zero register
package port_ctrl_zero_pkg;
   localparam int          NUM_PORTS       = 3;
   localparam logic [7:0]  PORT_ONE_OFS    = 8'h10;
   localparam logic [7:0]  PORT_TWO_OFS    = 8'h20;
   localparam logic [7:0]  PORT_THREE_OFS  = 8'h30;
   localparam int          BIT_STORM       = 7;
   localparam int          BIT_DSCP        = 6;
   localparam int          BIT_TAGPRIO     = 5;
   localparam int          BIT_PORTPRIO    = 4;
   localparam int          BIT_CEILING     = 3;
   localparam int          BIT_TAG_INSERT  = 2;
   localparam int          BIT_TAG_STRIP   = 1;
   localparam int          BIT_DUAL_QUEUE  = 0;
   localparam logic [7:0]  FIXED_RESET     = 8'h00;
   localparam logic [7:0]  STRAP_MASK      = 8'h37;
   localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
endpackage : port_ctrl_zero_pkg

// ==== port_ctrl_slice.sv ====
// one port's control zero register, loaded from its straps in reset; the decisions it steers are made in the top
module port_ctrl_slice
   import port_ctrl_zero_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // register access and reset straps
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   input  wire logic [4:0] strap_bits,
   // register contents
   output logic      [7:0] ctrl_q
);
   logic [7:0] ctrl_d;
   logic [4:0] strap;
   always_comb begin
      // straps fill bits 5,4,2,1,0; others come up zero
      strap  = strap_bits;
      ctrl_d = ctrl_q;
      if (!rst_n) begin
         ctrl_d = FIXED_RESET;
         ctrl_d[BIT_TAGPRIO]    = strap[4];
         ctrl_d[BIT_PORTPRIO]   = strap[3];
         ctrl_d[BIT_TAG_INSERT] = strap[2];
         ctrl_d[BIT_TAG_STRIP]  = strap[1];
         ctrl_d[BIT_DUAL_QUEUE] = strap[0];
      end else if (wr_en) begin
         ctrl_d = wr_data;
      end
   end
   always_ff @(posedge sys_clk) begin
      ctrl_q <= ctrl_d;
   end
endmodule : port_ctrl_slice

// ==== port_ingress_egress_control_zero.sv ====
// top: three per-port control zero registers and their per-packet decisions
// Notes on behaviour
// - bit 7 enables ingress broadcast storm protection
// - bit 6 enables DiffServ priority classification
// - bit 5 enables 802.1p priority classification
// - fallback: bit 4 gives high or low
// - OR of tag and DSCP overrides port
// - bit 3 caps user priority at default
// - bit 2 inserts tag on untagged egress
// - inserted tag carries ingress port's VID
// - bit 1 strips tag from tagged egress
// - bit 0 splits output queue high/low
// - single queue treats classes equally
// - same layout per port, distinct addresses
module port_ingress_egress_control_zero
   import port_ctrl_zero_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // management register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // strap pins, per port
   input  wire logic        strap_port_a_tagprio_enable,
   input  wire logic        strap_port_b_tagprio_enable,
   input  wire logic        strap_port_c_tagprio_enable,
   input  wire logic        strap_port_a_portprio,
   input  wire logic        strap_port_b_portprio,
   input  wire logic        strap_port_c_portprio,
   input  wire logic        strap_port_a_tag_insert,
   input  wire logic        strap_port_b_tag_insert,
   input  wire logic        strap_port_c_tag_insert,
   input  wire logic        strap_port_a_tag_strip,
   input  wire logic        strap_port_b_tag_strip,
   input  wire logic        strap_port_c_tag_strip,
   input  wire logic        strap_port_a_dual_queue,
   input  wire logic        strap_port_b_dual_queue,
   input  wire logic        strap_port_c_dual_queue,
   // ingress classification request, per port
   input  wire logic [2:0]  dscp_hit,
   input  wire logic [2:0]  dscp_high,
   input  wire logic [2:0]  tag_hit,
   input  wire logic [2:0]  tag_high,
   input  wire logic [8:0]  pkt_user_prio,
   input  wire logic [8:0]  default_user_prio,
   // egress request, per output port
   input  wire logic [2:0]  egr_rx_tagged,
   input  wire logic [5:0]  egr_src_port,
   input  wire logic [35:0] port_default_vid,
   // per-port decisions
   output logic      [2:0]  storm_protect,
   output logic      [2:0]  class_high,
   output logic      [8:0]  user_prio_out,
   output logic      [2:0]  egr_insert_tag,
   output logic      [2:0]  egr_strip_tag,
   output logic      [35:0] egr_insert_vid,
   output logic      [2:0]  queue_high
);
   // ------------------------------------------------------------
   // strap synchronisers
   // ------------------------------------------------------------
   logic [14:0] strap_raw;
   logic [14:0] strap_m_q;
   logic [14:0] strap_s_q;
   assign strap_raw = {strap_port_c_tagprio_enable, strap_port_c_portprio,
                       strap_port_c_tag_insert, strap_port_c_tag_strip,
                       strap_port_c_dual_queue,
                       strap_port_b_tagprio_enable, strap_port_b_portprio,
                       strap_port_b_tag_insert, strap_port_b_tag_strip,
                       strap_port_b_dual_queue,
                       strap_port_a_tagprio_enable, strap_port_a_portprio,
                       strap_port_a_tag_insert, strap_port_a_tag_strip,
                       strap_port_a_dual_queue};
   // straps are pins: two flops before use; reset must last 3 edges to see them
   always_ff @(posedge sys_clk) begin
      strap_m_q <= strap_raw;
      strap_s_q <= strap_m_q;
   end

   // ------------------------------------------------------------
   // register bank
   // ------------------------------------------------------------
   logic [7:0]  port_ofs [NUM_PORTS];
   logic [7:0]  ctrl     [NUM_PORTS];
   logic [2:0]  hit;
   assign port_ofs[0] = PORT_ONE_OFS;
   assign port_ofs[1] = PORT_TWO_OFS;
   assign port_ofs[2] = PORT_THREE_OFS;

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign hit[p] = (reg_addr == port_ofs[p]);
      port_ctrl_slice u_slice (
         .sys_clk    (sys_clk),
         .rst_n      (rst_n),
         .wr_en      (reg_wr && hit[p]),
         .wr_data    (reg_wdata),
         .strap_bits (strap_s_q[5*p +: 5]),
         .ctrl_q     (ctrl[p])
      );
   end

   // ------------------------------------------------------------
   // read data and per-packet decisions
   // ------------------------------------------------------------
   logic [7:0]  reg_rdata_d;
   logic [7:0]  reg_rdata_q;
   logic [2:0]  storm_d, class_d, ins_d, strip_d, queue_d;
   logic [8:0]  prio_d;
   logic [35:0] vid_d;
   always_comb begin
      logic [1:0] src;
      logic [2:0] up;
      src         = 2'h0;
      up          = 3'h0;
      reg_rdata_d = reg_rd ? UNMAPPED_DATA : reg_rdata_q;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (reg_rd && hit[p]) begin
            reg_rdata_d = ctrl[p];
         end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         storm_d[p] = ctrl[p][BIT_STORM];
         // tag/dscp results ORed override the port bit
         if ((ctrl[p][BIT_DSCP] && dscp_hit[p]) || (ctrl[p][BIT_TAGPRIO] && tag_hit[p])) begin
            class_d[p] = (ctrl[p][BIT_DSCP] && dscp_hit[p] && dscp_high[p])
                       | (ctrl[p][BIT_TAGPRIO] && tag_hit[p] && tag_high[p]);
         end else begin
            class_d[p] = ctrl[p][BIT_PORTPRIO];
         end
         up = pkt_user_prio[3*p +: 3];
         if (ctrl[p][BIT_CEILING] && up > default_user_prio[3*p +: 3]) begin
            up = default_user_prio[3*p +: 3];
         end
         prio_d[3*p +: 3] = up;
         ins_d[p]   = ctrl[p][BIT_TAG_INSERT] && !egr_rx_tagged[p];
         strip_d[p] = ctrl[p][BIT_TAG_STRIP] && egr_rx_tagged[p];
         src = egr_src_port[2*p +: 2];
         // vid of the receiving port, not of this output port
         vid_d[12*p +: 12] = (src == 2'h1) ? port_default_vid[12 +: 12] :
                             (src == 2'h2) ? port_default_vid[24 +: 12] :
                                             port_default_vid[0 +: 12];
         // single queue: every packet goes low, whatever its class
         queue_d[p] = ctrl[p][BIT_DUAL_QUEUE] && class_d[p];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata_q    <= 8'h00;
         storm_protect  <= 3'h0;
         class_high     <= 3'h0;
         user_prio_out  <= 9'h000;
         egr_insert_tag <= 3'h0;
         egr_strip_tag  <= 3'h0;
         egr_insert_vid <= 36'h0;
         queue_high     <= 3'h0;
      end else begin
         reg_rdata_q    <= reg_rdata_d;
         storm_protect  <= storm_d;
         class_high     <= class_d;
         user_prio_out  <= prio_d;
         egr_insert_tag <= ins_d;
         egr_strip_tag  <= strip_d;
         egr_insert_vid <= vid_d;
         queue_high     <= queue_d;
      end
   end
   assign reg_rdata = reg_rdata_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   storm_follow_a: assert property (##1 storm_protect[0] == $past(ctrl[0][BIT_STORM]))
      else $error("storm protect mismatch");
   dscp_class_a: assert property (ctrl[1][BIT_DSCP] && dscp_hit[1] && dscp_high[1]
      |=> class_high[1])
      else $error("dscp high lost");
   tag_class_a: assert property (ctrl[2][BIT_TAGPRIO] && tag_hit[2] && tag_high[2]
      |=> class_high[2])
      else $error("tag high lost");
   port_fallback_a: assert property (!dscp_hit[0] && !tag_hit[0]
      |=> class_high[0] == $past(ctrl[0][BIT_PORTPRIO]))
      else $error("port fallback wrong");
   override_low_a: assert property (ctrl[0][BIT_DSCP] && dscp_hit[0] && !dscp_high[0]
      && !(ctrl[0][BIT_TAGPRIO] && tag_hit[0]) |=> !class_high[0])
      else $error("override ignored");
   prio_ceiling_a: assert property (ctrl[0][BIT_CEILING]
      |=> user_prio_out[2:0] <= $past(default_user_prio[2:0]))
      else $error("ceiling exceeded");
   insert_untag_a: assert property (egr_rx_tagged[1] |=> !egr_insert_tag[1])
      else $error("tag added to tagged");
   insert_vid_a: assert property (egr_src_port[1:0] == 2'h2
      |=> egr_insert_vid[11:0] == $past(port_default_vid[35:24]))
      else $error("wrong vid");
   strip_tagged_a: assert property (!egr_rx_tagged[2] |=> !egr_strip_tag[2])
      else $error("untagged stripped");
   single_queue_a: assert property (!ctrl[1][BIT_DUAL_QUEUE] |=> !queue_high[1])
      else $error("queue split when single");
   reg_write_a: assert property (reg_wr && reg_addr == PORT_TWO_OFS
      |=> ctrl[1] == $past(reg_wdata))
      else $error("write lost");
   strap_load_a: assert property ($rose(rst_n) |-> ctrl[0][BIT_STORM] == 1'b0
      && ctrl[0][BIT_DUAL_QUEUE] == strap_s_q[0])
      else $error("reset value wrong");
   wr_cov: cover property (reg_wr && hit[2]);
   ins_cov: cover property (egr_insert_tag[0]);
   strip_cov: cover property (egr_strip_tag[1]);
   high_cov: cover property (queue_high[2]);
endmodule : port_ingress_egress_control_zero

// ==== testbench.sv ====
// testbench: per-port control zero registers, strap defaults and per-packet decisions
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import port_ctrl_zero_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic        strap_port_a_tagprio_enable = 1'b1, strap_port_b_tagprio_enable = 1'b0;
   logic        strap_port_c_tagprio_enable = 1'b1, strap_port_a_portprio = 1'b0;
   logic        strap_port_b_portprio = 1'b1, strap_port_c_portprio = 1'b1;
   logic        strap_port_a_tag_insert = 1'b1, strap_port_b_tag_insert = 1'b0;
   logic        strap_port_c_tag_insert = 1'b1, strap_port_a_tag_strip = 1'b0;
   logic        strap_port_b_tag_strip = 1'b1, strap_port_c_tag_strip = 1'b1;
   logic        strap_port_a_dual_queue = 1'b1, strap_port_b_dual_queue = 1'b0;
   logic        strap_port_c_dual_queue = 1'b1;
   logic [2:0]  dscp_hit = 3'h0, dscp_high = 3'h0, tag_hit = 3'h0, tag_high = 3'h0;
   logic [8:0]  pkt_user_prio = 9'h000, default_user_prio = 9'h000, user_prio_out;
   logic [2:0]  egr_rx_tagged = 3'h0, storm_protect, class_high, egr_insert_tag;
   logic [5:0]  egr_src_port = 6'h00;
   logic [35:0] port_default_vid = 36'h0, egr_insert_vid;
   logic [2:0]  egr_strip_tag, queue_high;
   int          n_errors = 0;
   int          checks = 0;

   port_ingress_egress_control_zero i_port_ingress_egress_control_zero (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .strap_port_a_tagprio_enable(strap_port_a_tagprio_enable),
      .strap_port_b_tagprio_enable(strap_port_b_tagprio_enable),
      .strap_port_c_tagprio_enable(strap_port_c_tagprio_enable),
      .strap_port_a_portprio(strap_port_a_portprio), .strap_port_b_portprio(strap_port_b_portprio),
      .strap_port_c_portprio(strap_port_c_portprio),
      .strap_port_a_tag_insert(strap_port_a_tag_insert),
      .strap_port_b_tag_insert(strap_port_b_tag_insert),
      .strap_port_c_tag_insert(strap_port_c_tag_insert),
      .strap_port_a_tag_strip(strap_port_a_tag_strip),
      .strap_port_b_tag_strip(strap_port_b_tag_strip),
      .strap_port_c_tag_strip(strap_port_c_tag_strip),
      .strap_port_a_dual_queue(strap_port_a_dual_queue),
      .strap_port_b_dual_queue(strap_port_b_dual_queue),
      .strap_port_c_dual_queue(strap_port_c_dual_queue),
      .dscp_hit(dscp_hit), .dscp_high(dscp_high), .tag_hit(tag_hit), .tag_high(tag_high),
      .pkt_user_prio(pkt_user_prio), .default_user_prio(default_user_prio),
      .egr_rx_tagged(egr_rx_tagged), .egr_src_port(egr_src_port),
      .port_default_vid(port_default_vid), .storm_protect(storm_protect),
      .class_high(class_high), .user_prio_out(user_prio_out), .egr_insert_tag(egr_insert_tag),
      .egr_strip_tag(egr_strip_tag), .egr_insert_vid(egr_insert_vid), .queue_high(queue_high));

   always #10 sys_clk = ~sys_clk;

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= addr;
      reg_wdata <= data;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= addr;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      chk("reg_rdata", {28'h0, exp}, {28'h0, reg_rdata});
   endtask : rd_chk

   // decisions are registered one cycle after their inputs; two edges leave margin
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_strap_defaults();
      rd_chk(PORT_ONE_OFS, 8'h25);
      rd_chk(PORT_TWO_OFS, 8'h12);
      rd_chk(PORT_THREE_OFS, 8'h37);
   endtask : test_strap_defaults

   task automatic test_map_and_unmapped();
      wr(PORT_ONE_OFS, 8'ha5);
      wr(PORT_TWO_OFS, 8'h5a);
      wr(PORT_THREE_OFS, 8'hc3);
      wr(8'h11, 8'hff);
      rd_chk(PORT_ONE_OFS, 8'ha5);
      rd_chk(PORT_TWO_OFS, 8'h5a);
      rd_chk(PORT_THREE_OFS, 8'hc3);
      rd_chk(8'h11, UNMAPPED_DATA);
   endtask : test_map_and_unmapped

   task automatic test_decisions();
      wr(PORT_ONE_OFS, 8'hc1);
      wr(PORT_TWO_OFS, 8'h30);
      wr(PORT_THREE_OFS, 8'h0d);
      dscp_hit <= 3'h7;
      dscp_high <= 3'h1;
      tag_hit <= 3'h7;
      tag_high <= 3'h0;
      pkt_user_prio <= {3'h6, 3'h2, 3'h7};
      default_user_prio <= {3'h3, 3'h5, 3'h1};
      egr_rx_tagged <= 3'h2;
      egr_src_port <= {2'h0, 2'h2, 2'h1};
      port_default_vid <= {12'h0a3, 12'h5c2, 12'h71e};
      settle();
      chk("storm_protect", 36'h1, {33'h0, storm_protect});
      chk("class_high", 36'h1, {33'h0, class_high});
      chk("queue_high", 36'h1, {33'h0, queue_high});
      chk("user_prio_out", {27'h0, 3'h3, 3'h2, 3'h7}, {27'h0, user_prio_out});
      chk("egr_insert_tag", 36'h4, {33'h0, egr_insert_tag});
      chk("egr_strip_tag", 36'h0, {33'h0, egr_strip_tag});
      chk("egr_insert_vid", 36'h71e, {24'h0, egr_insert_vid[35:24]});
      // tagged source stops hitting: port two falls back to its port priority bit
      wr(PORT_TWO_OFS, 8'h32);
      tag_hit <= 3'h0;
      egr_rx_tagged <= 3'h3;
      settle();
      chk("class_high", 36'h3, {33'h0, class_high});
      chk("queue_high", 36'h1, {33'h0, queue_high});
      chk("egr_insert_tag", 36'h4, {33'h0, egr_insert_tag});
      chk("egr_strip_tag", 36'h2, {33'h0, egr_strip_tag});
      wr(PORT_ONE_OFS, 8'h00);
      settle();
      chk("storm_protect", 36'h0, {33'h0, storm_protect});
      chk("class_high", 36'h2, {33'h0, class_high});
   endtask : test_decisions

   // a low result from an enabled source must beat a high port bit; ceiling on that same lane, vid on every lane
   task automatic test_override_ceiling();
      wr(PORT_ONE_OFS, 8'h58);
      wr(PORT_TWO_OFS, 8'h41);
      wr(PORT_THREE_OFS, 8'h20);
      dscp_hit <= 3'h3;
      dscp_high <= 3'h2;
      tag_hit <= 3'h4;
      tag_high <= 3'h4;
      pkt_user_prio <= {3'h1, 3'h4, 3'h5};
      default_user_prio <= {3'h0, 3'h0, 3'h2};
      egr_src_port <= {2'h1, 2'h0, 2'h2};
      port_default_vid <= {12'h3c5, 12'h9e1, 12'h04b};
      settle();
      chk("class_high", 36'h6, {33'h0, class_high});
      chk("queue_high", 36'h2, {33'h0, queue_high});
      chk("user_prio_out", {27'h0, 3'h1, 3'h4, 3'h2}, {27'h0, user_prio_out});
      chk("egr_insert_vid", {12'h9e1, 12'h04b, 12'h3c5}, egr_insert_vid);
   endtask : test_override_ceiling

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic stop_test();
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      test_strap_defaults();
      test_map_and_unmapped();
      test_decisions();
      test_override_ceiling();
      stop_test();
   end

   // whole run is well under a thousand cycles; this limit only catches a hang
   initial begin
      #100us;
      n_errors++;
      stop_test();
   end
endmodule : testbench
